// ### rtl/ecr_ep0_handler.sv
// control endpoint zero request handler with apb register access
// Function
// - set interface raises setup request flag
// - non-standard no-data request holds status stage
// - set interface status acknowledged without master
// - each setup packet overwrites the setup buffer
// - get status always reports bus powered
// - self powered flag cleared, never updated
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module ecr_ep0_handler
	import ecr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// usb engine side
	input wire logic setup_start_i,
	input wire logic setup_byte_valid_i,
	input wire logic [7:0] setup_byte_i,
	input wire logic status_in_i,
	input wire logic get_status_i,
	output logic status_ack_o,
	output logic status_nak_o,
	output logic [15:0] status_word_o,
	// master notification
	output logic setup_req_o
);
	logic [1:0] rst_sync;
	ecr_state_t state;
	logic [2:0] byte_cnt, rd_ptr;
	logic [7:0] req_type, req_code, ep0_byte_count, mem_rdata;
	ecr_req_t req;
	logic rst_n, len_nonzero, pending, held, self_powered;
	logic mem_wr, acc, done, wr_done, ep0bc_zero_wr, ctrl_clr_wr;
	logic decode_irq, decode_hold, rd_err;
	logic [31:0] rd_mux;

	// ==========================================
	// reset synchroniser
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ==========================================
	// setup packet capture
	assign mem_wr = (state == ST_COLLECT) && setup_byte_valid_i;

	// a new setup start restarts capture, dropping any partial packet
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			byte_cnt <= 3'h0;
		end else if (setup_start_i) begin
			state <= ST_COLLECT;
			byte_cnt <= 3'h0;
		end else begin
			case (state)
				ST_COLLECT: begin
					if (setup_byte_valid_i) begin
						byte_cnt <= byte_cnt + 3'h1;
						if (byte_cnt == SETUP_LAST) begin
							state <= ST_DECODE;
						end
					end
				end
				ST_DECODE: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// request header bytes kept aside so decode needs no memory read
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			req_type <= 8'h00;
			req_code <= 8'h00;
			len_nonzero <= 1'b0;
		end else if (mem_wr) begin
			if (byte_cnt == 3'h0) begin
				req_type <= setup_byte_i;
			end
			if (byte_cnt == 3'h1) begin
				req_code <= setup_byte_i;
			end
			if (byte_cnt == 3'h6) begin
				len_nonzero <= (setup_byte_i != 8'h00);
			end
			if (byte_cnt == SETUP_LAST) begin
				len_nonzero <= len_nonzero | (setup_byte_i != 8'h00);
			end
		end
	end

	// request classification
	always_comb begin
		req.is_std = (req_type[6:5] == 2'b00);
		req.set_intf = req.is_std && (req_code == REQ_SET_INTERFACE);
		req.get_stat_dev = req.is_std && (req_code == REQ_GET_STATUS) && (req_type[4:0] == 5'h00);
		req.has_data = len_nonzero;
	end
	assign decode_irq = (state == ST_DECODE) && (req.set_intf || !req.is_std);
	assign decode_hold = (state == ST_DECODE) && !req.is_std && !req.has_data;
	// packet store, written straight over any unread packet
	ecr_setup_mem #(
		.DW(8),
		.DEPTH(8),
		.AW(3)
	) u_mem (
		.clk_sys_i(clk_sys_i),
		.wr_en_i(mem_wr),
		.wr_addr_i(byte_cnt),
		.wr_data_i(setup_byte_i),
		.rd_addr_i(rd_ptr),
		.rd_data_o(mem_rdata)
	);

	// ==========================================
	// apb slave: one wait state, writes at the completing edge
	assign acc = psel_i && penable_i && !pready_o;
	assign done = psel_i && penable_i && pready_o;
	assign wr_done = done && pwrite_i;
	assign ep0bc_zero_wr = wr_done && (paddr_i == ADDR_EP0BC) && (pwdata_i[7:0] == 8'h00);
	assign ctrl_clr_wr = wr_done && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_PENDING_BIT];

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr_i == ADDR_SETUP) begin
			rd_mux = {24'h00_0000, mem_rdata};
		end else if (paddr_i == ADDR_EP0BC) begin
			rd_mux = {24'h00_0000, ep0_byte_count};
		end else if (paddr_i == ADDR_CTRL) begin
			rd_mux[CTRL_PENDING_BIT] = pending;
			rd_mux[CTRL_HELD_BIT] = held;
			rd_mux[CTRL_SELFPWR_BIT] = self_powered;
		end else begin
			rd_err = 1'b1;
		end
	end

	// answer flops; read data held through the ready cycle
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= acc;
			pslverr_o <= acc && rd_err;
			if (acc) begin
				prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// byte count register
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ep0_byte_count <= EP0BC_RESET;
		end else if (wr_done && (paddr_i == ADDR_EP0BC)) begin
			ep0_byte_count <= pwdata_i[7:0];
		end
	end

	// setup buffer read pointer, rewound for each new packet
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr <= 3'h0;
		end else if (state == ST_DECODE) begin
			rd_ptr <= 3'h0;
		end else if (done && !pwrite_i && (paddr_i == ADDR_SETUP)) begin
			rd_ptr <= rd_ptr + 3'h1;
		end
	end

	// ==========================================
	// master notification and status stage
	// set beats a clear in the same cycle
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (decode_irq) begin
			pending <= 1'b1;
		end else if (ctrl_clr_wr) begin
			pending <= 1'b0;
		end
	end

	// set interface never sets held, so its status goes out alone
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			held <= 1'b0;
		end else if (decode_hold) begin
			held <= 1'b1;
		end else if (ep0bc_zero_wr || setup_start_i) begin
			held <= 1'b0;
		end
	end

	// status handshake answers, one-cycle pulses
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			status_ack_o <= 1'b0;
			status_nak_o <= 1'b0;
		end else begin
			status_ack_o <= status_in_i && !held;
			status_nak_o <= status_in_i && held;
		end
	end

	// flag loaded at reset only; descriptors never reach it
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			self_powered <= SELFPWR_RESET;
		end
	end

	// get status word: self powered bit is bit 0
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			status_word_o <= 16'h0000;
			setup_req_o <= 1'b0;
		end else begin
			setup_req_o <= pending || decode_irq;
			if (get_status_i) begin
				status_word_o <= {15'h0000, self_powered};
			end
		end
	end

	// ==========================================
	// assertions
	sequence s_set_if_decoded;
		(state == ST_DECODE) && req.set_intf;
	endsequence
	sequence s_nostd_nodata_decoded;
		(state == ST_DECODE) && !req.is_std && !req.has_data;
	endsequence
	property p_set_if_irq;
		@(posedge clk_sys_i) disable iff (!rst_n) s_set_if_decoded |=> pending ##1 setup_req_o;
	endproperty
	a_set_if_irq: assert property (p_set_if_irq) else $error("set interface did not raise flag");
	property p_hold_status;
		@(posedge clk_sys_i) disable iff (!rst_n) s_nostd_nodata_decoded |=> held && pending;
	endproperty
	a_hold_status: assert property (p_hold_status) else $error("no-data request not held");
	property p_hold_keeps;
		@(posedge clk_sys_i) disable iff (!rst_n)
			held && !ep0bc_zero_wr && !setup_start_i && status_in_i |=> status_nak_o && !status_ack_o;
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("status acked while held");
	property p_set_if_auto_ack;
		@(posedge clk_sys_i) disable iff (!rst_n) s_set_if_decoded |=> !held;
	endproperty
	a_set_if_auto_ack: assert property (p_set_if_auto_ack) else $error("set interface left status held");
	property p_free_ack;
		@(posedge clk_sys_i) disable iff (!rst_n) !held && status_in_i |=> status_ack_o && !status_nak_o;
	endproperty
	a_free_ack: assert property (p_free_ack) else $error("unheld status not acked");
	property p_rewind;
		@(posedge clk_sys_i) disable iff (!rst_n) (state == ST_DECODE) |=> (rd_ptr == 3'h0);
	endproperty
	a_rewind: assert property (p_rewind) else $error("setup buffer not rewound");
	property p_bus_powered;
		@(posedge clk_sys_i) disable iff (!rst_n) get_status_i |=> (status_word_o == 16'h0000);
	endproperty
	a_bus_powered: assert property (p_bus_powered) else $error("get status not bus powered");
	property p_selfpwr_zero;
		@(posedge clk_sys_i) disable iff (!rst_n) ctrl_clr_wr || acc |-> !self_powered && !rd_mux[CTRL_SELFPWR_BIT];
	endproperty
	a_selfpwr_zero: assert property (p_selfpwr_zero) else $error("self powered flag set");
	property p_irq_after_full;
		@(posedge clk_sys_i) disable iff (!rst_n) $rose(pending) |-> $past(state == ST_DECODE) && $past(byte_cnt) == 3'h0;
	endproperty
	a_irq_after_full: assert property (p_irq_after_full) else $error("flag before full packet");
endmodule

// ### rtl/ecr_pkg.sv
// package: constants and types for the control endpoint zero request handler
package ecr_pkg;
	// ==========================================
	// register indices and byte addresses
	localparam logic [7:0] IDX_SETUP = 8'h32;
	localparam logic [7:0] IDX_EP0BC = 8'h33;
	localparam logic [7:0] IDX_CTRL = 8'h34;
	localparam logic [11:0] ADDR_SETUP = {2'b00, IDX_SETUP, 2'b00};
	localparam logic [11:0] ADDR_EP0BC = {2'b00, IDX_EP0BC, 2'b00};
	localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
	// ==========================================
	// control/status field positions
	localparam int CTRL_PENDING_BIT = 0;
	localparam int CTRL_HELD_BIT = 1;
	localparam int CTRL_SELFPWR_BIT = 2;
	// ==========================================
	// setup packet layout and request codes
	localparam logic [3:0] SETUP_LEN = 4'h8;
	localparam logic [2:0] SETUP_LAST = 3'h7;
	localparam logic [7:0] REQ_GET_STATUS = 8'h00;
	localparam logic [7:0] REQ_SET_INTERFACE = 8'h0b;
	// ==========================================
	// reset values
	localparam logic [7:0] EP0BC_RESET = 8'h00;
	localparam logic SELFPWR_RESET = 1'b0;
	// ==========================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_COLLECT = 3'b010,
		ST_DECODE = 3'b100
	} ecr_state_t;
	typedef struct packed {
		logic is_std;
		logic set_intf;
		logic get_stat_dev;
		logic has_data;
	} ecr_req_t;
endpackage

// ### rtl/ecr_setup_mem.sv
// setup packet store with registered read data
`timescale 1ns/10ps
module ecr_setup_mem #(
	parameter int DW = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// clock
	input wire logic clk_sys_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [DW-1:0] wr_data_i,
	// read port
	input wire logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o
);
	logic [DW-1:0] mem [DEPTH];

	// ==========================================
	// write, then registered read
	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// read data registered, so a write shows one cycle later
	always_ff @(posedge clk_sys_i) begin
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

// ### tb/ecr_host_model.sv
// usb host side model driving the engine inputs of the request handler
`timescale 1ns/10ps
module ecr_host_model (
	// clock
	input wire logic clk_sys_i,
	// engine inputs of the block
	output logic setup_start_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o,
	output logic status_in_o,
	output logic get_status_o
);
	// ==========================================
	// idle levels at time zero
	initial begin
		setup_start_o = 1'b0;
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
		status_in_o = 1'b0;
		get_status_o = 1'b0;
	end
	// one setup packet, byte 0 first, gap cycle after each byte but the last
	task automatic send_setup(input logic [63:0] pkt);
		@(posedge clk_sys_i);
		setup_start_o <= 1'b1;
		@(posedge clk_sys_i);
		setup_start_o <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			byte_valid_o <= 1'b1;
			byte_o <= pkt[8*i +: 8];
			@(posedge clk_sys_i);
			byte_valid_o <= 1'b0;
			byte_o <= ~pkt[8*i +: 8]; // stale bus must not look valid
			if (i < 7) begin
				@(posedge clk_sys_i);
			end
		end
	endtask
	// one token pulse: status stage or get status
	task automatic token(input logic gs);
		@(posedge clk_sys_i);
		get_status_o <= gs;
		status_in_o <= ~gs;
		@(posedge clk_sys_i);
		get_status_o <= 1'b0;
		status_in_o <= 1'b0;
	endtask
endmodule

// ### tb/ep0_control_request_handler_tb.sv
// self-checking bench for the control endpoint zero request handler
`timescale 1ns/10ps
module ep0_control_request_handler_tb;
	import ecr_pkg::*;
	localparam logic [63:0] P_INTF = {48'h0000_0000_0001, REQ_SET_INTERFACE, 8'h01};
	localparam logic [63:0] P_NEXT = {48'h0000_0000_0002, REQ_SET_INTERFACE, 8'h01};
	localparam logic [63:0] P_VEND = {48'h0, 8'ha5, 8'h40};
	// vendor request with a data stage: length high byte set, so no hold
	localparam logic [63:0] P_VDAT = {16'h0100, 32'h0, 8'ha5, 8'h40};
	// attributes the master loads: bus powered, self powered bit 6 clear
	localparam logic [7:0] DESC_ATTR = 8'h80;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, status_ack, status_nak, setup_req;
	logic [15:0] status_word;
	logic setup_start, byte_valid, status_in, get_status;
	logic [7:0] setup_byte;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	// ==========================================
	// clock and instances
	always #2.5 clk_sys = ~clk_sys;
	ecr_ep0_handler i_dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .setup_start_i(setup_start), .setup_byte_valid_i(byte_valid),
		.setup_byte_i(setup_byte), .status_in_i(status_in), .get_status_i(get_status),
		.status_ack_o(status_ack), .status_nak_o(status_nak), .status_word_o(status_word),
		.setup_req_o(setup_req));
	ecr_host_model i_host (.clk_sys_i(clk_sys), .setup_start_o(setup_start), .byte_valid_o(byte_valid),
		.byte_o(setup_byte), .status_in_o(status_in), .get_status_o(get_status));
	// ==========================================
	// checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end
	// ==========================================
	// apb transfer: setup, access, hold until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_pkt(input logic [63:0] p);
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, ADDR_SETUP, 32'h0, r, e);
			chk(r, {24'h0, p[8*i +: 8]});
		end
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	// ==========================================
	// scenarios
	task automatic t_intf;
		i_host.send_setup(P_INTF);
		#1 chk({31'h0, setup_req}, 32'h0);
		repeat (3) @(posedge clk_sys);
		#1 chk({31'h0, setup_req}, 32'h1);
		rd_pkt(P_INTF);
		i_host.token(1'b0);
		#1 chk({30'h0, status_ack, status_nak}, 32'h2);
		wr(ADDR_CTRL, 32'h1);
	endtask
	task automatic t_vendor;
		i_host.send_setup(P_VEND);
		repeat (3) @(posedge clk_sys);
		#1 chk({31'h0, setup_req}, 32'h1);
		rd_chk(ADDR_CTRL, 32'h3);
		i_host.token(1'b0);
		#1 chk({30'h0, status_ack, status_nak}, 32'h1);
		wr(ADDR_EP0BC, 32'h0);
		i_host.token(1'b0);
		#1 chk({30'h0, status_ack, status_nak}, 32'h2);
		wr(ADDR_CTRL, 32'h1);
		i_host.send_setup(P_VDAT);
		repeat (3) @(posedge clk_sys);
		rd_chk(ADDR_CTRL, 32'h1);
		i_host.token(1'b0);
		#1 chk({30'h0, status_ack, status_nak}, 32'h2);
		wr(ADDR_CTRL, 32'h1);
	endtask
	task automatic t_overwrite;
		i_host.send_setup(P_INTF);
		i_host.send_setup(P_NEXT);
		rd_pkt(P_NEXT);
		wr(ADDR_CTRL, 32'h1);
	endtask
	task automatic t_status;
		i_host.token(1'b1);
		#1 chk({16'h0000, status_word}, 32'h0);
		chk({16'h0000, status_word}, {31'h0, DESC_ATTR[6]});
		rd_chk(ADDR_CTRL, 32'h0);
	endtask
	task automatic t_unmapped;
		logic [31:0] r;
		logic e;
		apb(1'b0, 12'h000, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd_chk(ADDR_CTRL, 32'h0);
		t_intf();
		t_vendor();
		t_overwrite();
		t_status();
		t_unmapped();
		final_report();
	end
endmodule
